// ==== logic/ddi_drive_if.sv ====
// Purpose: Input interface, select and dual-access arbitration of a disk drive.
// Assumes: Cable pins are asynchronous; exerciser and drive_ready are on aclk.
// Notes:   Summary of operation follows.
// Summary of operation
// (R01) Asserted sequence request powers the drive up; deasserted powers it down.
// (R02) Asserted unit select lets the drive take bus commands and data.
// (R03) Each access request enables arbitration before that controller can select.
// (R04) Controller holds bus lines 200 ns around every tag strobe.
// (R05) Cylinder strobe loads cylinder address; its release launches the seek.
// (R06) Head strobe loads head address and offset from the bus.
// (R07) Command strobe makes the selected drive decode the bus as commands.
// (R08) Online switch sets the control latch; controller owns the interface.
// (R09) Offline switch resets the latch; exerciser supplies commands.
// (R10) Offline forces power-sequence enable; operator start switch then rules; the code has no start switch and holds it high while offline.
// (R11) Offline disables the input interface and most of the output interface.
// (R12) Power-sequence enable needs request plus terminator power, or offline.
// (R13) Powered and ready drive raises attention whether selected or not.
// (R14) Unselected drive ignores commands and presents no bus status.
// (R15) Access requires bused cables, terminator and controller terminator power.
// (R16) Online with terminator, select drives the select acknowledge.
// (R17) Select acknowledge locks the write-protect switch and enables receivers.
// (R18) Connected lines feed read/write selection; low B hold disables B.
// (R19) No unit-address decoding; the wired radial cable decides.
// (R20) Only one controller owns the drive at a time, time-sliced.
// (R21) Operator access enables override requests and automatic arbitration.
// (R22) Each access has a fail-safe timer releasing a hung access.
// (R23) All inputs except controller terminator power are low-true; the code also takes terminator_power_in as high-true.
// (R24) Cylinder above 814 flags illegal cylinder and suppresses the seek.
// (R25) End of cylinder asserts when head address exceeds 18.
// (R26) Asynchronous inputs pass a two-flop synchroniser before use.
`timescale 1ns/10ps

module ddi_drive_if
#(
    parameter int unsigned FAILSAFE_COUNT = ddi_pkg::FAILSAFE_CYCLES
)
(
    // Clock and reset.
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // Cable pins and local sources.
    input  wire ddi_pkg::ddi_pins_t pins,
    input  wire ddi_pkg::ddi_exer_t exer,
    input  wire logic            drive_ready,
    // Drive control outputs.
    output logic                 unit_power_sequence_enable,
    output logic                 select_acknowledge,
    output logic                 attention,
    output logic                 bus_receivers_enabled,
    output logic                 rw_switch_lockout,
    output logic                 input_interface_disable,
    output logic                 output_interface_disable,
    output logic                 access_a_connected,
    output logic                 access_b_connected,
    output logic                 rw_select_a,
    output logic                 rw_select_b,
    // Positioning and command outputs.
    output logic                 seek_start,
    output logic [9:0]           cylinder_address,
    output logic [4:0]           head_address,
    output logic [1:0]           offset_command,
    output logic                 illegal_cylinder,
    output logic                 end_of_cylinder,
    output logic                 command_valid,
    output logic [9:0]           command_word,
    // AXI4-Lite slave.
    input  wire logic [3:0]      awaddr,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    input  wire logic            wvalid,
    output logic                 wready,
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input  wire logic            bready,
    input  wire logic [3:0]      araddr,
    input  wire logic            arvalid,
    output logic                 arready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input  wire logic            rready
);
    import ddi_pkg::*;

    ddi_state_t s;
    ddi_state_t next_s;
    logic [1:0] tmo;
    logic       online;
    logic       seq;
    logic       sel;
    logic       req_a;
    logic       req_b;
    logic       access_ok;
    logic       sel_ok;
    logic       tag_act;
    logic       auto_m;
    logic       force_a;
    logic       force_b;
    logic [9:0] e_bus;
    logic       e_cyl;
    logic       e_head;
    logic       e_cmd;
    logic [31:0] status_word;

    // Decode synchronised pins; every cable line but terminator power is low-true.
    assign online    = s.ctrl[CTRL_ONLINE];                                  // R08 R09
    assign seq       = ~s.sync2.power_sequence_request_n;                    // R23
    assign sel       = ~s.sync2.unit_select_line_n;
    assign req_a     = ~s.sync2.access_a_request_n;                          // R03
    assign req_b     = ~s.sync2.access_b_request_n;
    assign access_ok = ~s.sync2.cables_present_n & ~s.sync2.terminator_present_n
                       & s.sync2.controller_terminator_power;                // R15
    assign tag_act   = ~s.sync2.cylinder_load_strobe_n | ~s.sync2.head_load_strobe_n
                       | ~s.sync2.command_strobe_n;

    // Selection exists only through the wired radial select; no address compare.
    assign sel_ok = online & access_ok & sel & (s.conn != CONN_NONE);        // R16 R19 R02

    // Operator switches decide the arbitration mode.
    assign auto_m  = s.ctrl[CTRL_EN_A] & s.ctrl[CTRL_EN_B];                  // R21
    assign force_a = s.ctrl[CTRL_EN_A] & ~s.ctrl[CTRL_EN_B];
    assign force_b = ~s.ctrl[CTRL_EN_A] & s.ctrl[CTRL_EN_B];

    // Offline the exerciser replaces the cable; online an unselected drive sees nothing.
    assign e_bus  = online ? ~s.sync2.command_bus_lines_n : exer.bus;        // R09
    assign e_cyl  = online ? (sel_ok & ~s.sync2.cylinder_load_strobe_n) : exer.cyl_strobe; // R14
    assign e_head = online ? (sel_ok & ~s.sync2.head_load_strobe_n) : exer.head_strobe;
    assign e_cmd  = online ? (sel_ok & ~s.sync2.command_strobe_n) : exer.cmd_strobe;

    // Drive control outputs.
    assign unit_power_sequence_enable = (seq & s.sync2.terminator_power_in) | ~online; // R01 R10 R12
    assign select_acknowledge         = sel_ok;                              // R16
    assign bus_receivers_enabled      = sel_ok;                              // R17
    assign rw_switch_lockout          = sel_ok;                              // R17
    assign input_interface_disable    = ~online;                             // R11
    assign output_interface_disable   = ~online;                             // R11
    assign access_a_connected         = (s.conn == CONN_A);
    assign access_b_connected         = (s.conn == CONN_B);
    assign rw_select_a = sel_ok & access_a_connected;                        // R18
    assign rw_select_b = sel_ok & access_b_connected & s.sync2.b_connected_hold_n; // R18
    assign attention                  = s.attention;
    assign seek_start                 = s.seek_start;
    assign cylinder_address           = s.cyl;
    assign head_address               = s.head;
    assign offset_command             = s.offset;
    assign illegal_cylinder           = s.illegal;
    assign end_of_cylinder            = (s.head > MAX_HEAD);                 // R25
    assign command_valid              = s.cmd_valid;
    assign command_word               = s.cmd;

    // Bus handshakes: each channel holds one item until its response is taken.
    assign awready = ~s.aw_full;
    assign wready  = ~s.w_full;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign arready = ~s.rvalid;
    assign rvalid  = s.rvalid;
    assign rdata   = s.rdata;
    assign rresp   = s.rresp;

    assign status_word = {22'h000000, req_b, req_a, end_of_cylinder, access_b_connected,
                          access_a_connected, s.illegal, s.attention, sel_ok,
                          unit_power_sequence_enable, online};

    // Next-state logic for the whole block.
    always_comb
    begin
        next_s       = s;
        tmo          = 2'h0;
        next_s.sync1 = pins;                                                 // R26
        next_s.sync2 = s.sync1;                                              // R26
        next_s.seek_start = 1'b0;
        next_s.attention  = drive_ready & online;                            // R13

        // Fail-safe timers: run only while the owner idles and the other side waits.
        for (int i = 0; i < 2; i++)
        begin
            if (auto_m && (i == 0 ? (access_a_connected && req_b)
                                  : (access_b_connected && req_a)) && !tag_act)
            begin
                if (s.timer[i] == 32'h00000000)
                begin
                    tmo[i]          = 1'b1;                                  // R22
                    next_s.timer[i] = 32'(FAILSAFE_COUNT - 1);
                end
                else
                begin
                    next_s.timer[i] = s.timer[i] - 32'h00000001;
                end
            end
            else
            begin
                // Tag activity acts like the retriggered one-shot and reloads.
                next_s.timer[i] = 32'(FAILSAFE_COUNT - 1);
            end
        end

        // Access ownership; switch settings always win over requests.
        unique case (s.conn)
            CONN_NONE:
            begin
                if (force_a || (auto_m && req_a))                            // R03 R21
                    next_s.conn = CONN_A;
                else if (force_b || (auto_m && req_b))
                    next_s.conn = CONN_B;
            end
            CONN_A:
            begin
                if (force_b)                                                 // R21
                    next_s.conn = CONN_B;
                else if (!s.ctrl[CTRL_EN_A] || (auto_m && !req_a))
                    next_s.conn = CONN_NONE;
                else if (tmo[0])                                             // R20 R22
                    next_s.conn = CONN_B;
            end
            CONN_B:
            begin
                if (force_a)
                    next_s.conn = CONN_A;
                else if (!s.ctrl[CTRL_EN_B] || (auto_m && !req_b))
                    next_s.conn = CONN_NONE;
                else if (tmo[1])
                    next_s.conn = CONN_A;
            end
            default:
            begin
                next_s.conn = CONN_NONE;
            end
        endcase

        // Command decode; actions fire once on the strobe's leading edge.
        next_s.cmd_prev  = e_cmd;
        next_s.cmd_valid = e_cmd;                                            // R07
        if (e_cmd)
            next_s.cmd = e_bus;
        if (e_cmd && !s.cmd_prev)
        begin
            if (e_bus[CMD_REZERO_BIT])
            begin
                next_s.cyl     = 10'h000;
                next_s.illegal = 1'b0;
            end
            if (e_bus[CMD_HAR_RESET_BIT])
                next_s.head = 5'h00;
            else if (e_bus[CMD_HEAD_ADV_BIT])
                next_s.head = 5'(s.head + 5'h01);
        end

        // Head and offset load while the head strobe is low.
        if (e_head)
        begin
            next_s.head   = e_bus[HEAD_LSB +: HEAD_W];                       // R06
            next_s.offset = {e_bus[OFFSET_REV_BIT], e_bus[OFFSET_FWD_BIT]};  // R06
        end

        // Cylinder load while strobed; the release launches or refuses the seek.
        next_s.cyl_prev = e_cyl;
        if (e_cyl)
            next_s.cyl = e_bus;                                              // R05
        if (!e_cyl && s.cyl_prev)
        begin
            if (s.cyl > MAX_CYLINDER)
                next_s.illegal = 1'b1;                                       // R24
            else
                next_s.seek_start = 1'b1;                                    // R05
        end

        // Write channel: address and data taken in either order.
        if (awvalid && !s.aw_full)
        begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && !s.w_full)
        begin
            next_s.w_full = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (s.aw_full && s.w_full && !s.bvalid)
        begin
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            if (s.aw_addr[3:2] == REG_CTRL[3:2])
            begin
                if (s.w_strb[0])
                    next_s.ctrl = s.w_data[2:0];
            end
            else if (s.aw_addr[3:2] != REG_STATUS[3:2]
                     && s.aw_addr[3:2] != REG_POSITION[3:2])
            begin
                next_s.bresp = RESP_SLVERR;
            end
        end
        if (s.bvalid && bready)
        begin
            next_s.bvalid  = 1'b0;
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
        end

        // Read channel: one cycle from address to data.
        if (s.rvalid && rready)
            next_s.rvalid = 1'b0;
        if (arvalid && !s.rvalid)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            if (araddr[3:2] == REG_CTRL[3:2])
                next_s.rdata = {29'h00000000, s.ctrl};
            else if (araddr[3:2] == REG_STATUS[3:2])
                next_s.rdata = status_word;
            else if (araddr[3:2] == REG_POSITION[3:2])
                next_s.rdata = {6'h00, s.offset, 3'h0, s.head, 6'h00, s.cyl};
            else
            begin
                next_s.rdata = 32'h00000000;
                next_s.rresp = RESP_SLVERR;
            end
        end
    end

    // State register; synchronous active-low reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s <= STATE_RESET;
        else
            s <= next_s;
    end

    // Checks on the block's own behaviour.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_upse_offline: assert property (!online |-> unit_power_sequence_enable) // R10
        else $error("power sequence enable low while offline");
    chk_upse_online: assert property (online && !(seq && s.sync2.terminator_power_in)
        |-> !unit_power_sequence_enable) // R12
        else $error("power sequence enable without request and terminator power");
    chk_seek_launch: assert property ($fell(e_cyl) && s.cyl <= MAX_CYLINDER
        |=> seek_start ##1 !seek_start) // R05
        else $error("legal cylinder release did not pulse seek start once");
    chk_illegal_cyl: assert property ($fell(e_cyl) && s.cyl > MAX_CYLINDER
        |=> illegal_cylinder && !seek_start) // R24
        else $error("illegal cylinder not flagged or seek launched");
    chk_head_eoc: assert property (e_head && e_bus[HEAD_LSB +: HEAD_W] > MAX_HEAD
        |=> end_of_cylinder) // R25
        else $error("end of cylinder missing after high head load");
    chk_cmd_gated: assert property (online && !select_acknowledge |=> !command_valid) // R14
        else $error("command decoded while not selected");
    chk_one_owner: assert property ($onehot(s.conn)
        && !(rw_select_a && rw_select_b)) // R20
        else $error("two accesses own the drive");
    chk_timer_release: assert property (access_a_connected && tmo[0]
        && s.ctrl[CTRL_EN_A] && auto_m && req_a |=> access_b_connected) // R22
        else $error("fail-safe timeout did not hand the drive over");
    chk_switch_prec: assert property (!s.ctrl[CTRL_EN_A] |=> !access_a_connected) // R21
        else $error("disabled access still connected");
    chk_attention: assert property (drive_ready && online |=> attention) // R13
        else $error("attention missing for ready drive");
    chk_sel_ack: assert property ($rose(sel_ok) |-> select_acknowledge
        && bus_receivers_enabled && rw_switch_lockout) // R16
        else $error("select acknowledge side effects missing");

endmodule

// ==== shared/ddi_pkg.sv ====
// Purpose: Shared types and constants for the drive input interface block.
// Assumes: 20 MHz aclk; all cable pins arrive asynchronously.
// Notes:   Pin struct fields ending in _n are low-true at the cable.
package ddi_pkg;

    // Clock and fail-safe timing.
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned FAILSAFE_TIME_MS = 1300;
    localparam int unsigned FAILSAFE_CYCLES  = FAILSAFE_TIME_MS * (CLK_HZ / 1000);

    // Address and head limits.
    localparam logic [9:0] MAX_CYLINDER = 10'h32E;
    localparam logic [4:0] MAX_HEAD     = 5'h12;

    // Bus field layout for head load and command decode.
    localparam int HEAD_LSB          = 0;
    localparam int HEAD_W            = 5;
    localparam int OFFSET_FWD_BIT    = 8;
    localparam int OFFSET_REV_BIT    = 9;
    localparam int CMD_HAR_RESET_BIT = 4;
    localparam int CMD_HEAD_ADV_BIT  = 5;
    localparam int CMD_REZERO_BIT    = 6;

    // Register offsets and control fields.
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_STATUS   = 4'h4;
    localparam logic [3:0] REG_POSITION = 4'h8;
    localparam int         CTRL_ONLINE  = 0;
    localparam int         CTRL_EN_A    = 1;
    localparam int         CTRL_EN_B    = 2;
    localparam logic [2:0] CTRL_RESET   = 3'h7;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    // Raw cable pins, sampled as one group.
    typedef struct packed {
        logic       power_sequence_request_n;
        logic       unit_select_line_n;
        logic       access_a_request_n;
        logic       access_b_request_n;
        logic [9:0] command_bus_lines_n;
        logic       cylinder_load_strobe_n;
        logic       head_load_strobe_n;
        logic       command_strobe_n;
        logic       terminator_present_n;
        logic       cables_present_n;
        logic       b_connected_hold_n;
        logic       terminator_power_in;
        logic       controller_terminator_power;
    } ddi_pins_t;

    // Maintenance exerciser inputs, high-true, on aclk.
    typedef struct packed {
        logic [9:0] bus;
        logic       cyl_strobe;
        logic       head_strobe;
        logic       cmd_strobe;
    } ddi_exer_t;

    typedef enum logic [2:0] {
        CONN_NONE = 3'b001,
        CONN_A    = 3'b010,
        CONN_B    = 3'b100
    } ddi_conn_t;

    typedef struct packed {
        ddi_pins_t        sync1;
        ddi_pins_t        sync2;
        logic [2:0]       ctrl;
        ddi_conn_t        conn;
        logic [1:0][31:0] timer;
        logic             cyl_prev;
        logic             cmd_prev;
        logic [9:0]       cyl;
        logic [4:0]       head;
        logic [1:0]       offset;
        logic             illegal;
        logic             seek_start;
        logic             cmd_valid;
        logic [9:0]       cmd;
        logic             attention;
        logic             aw_full;
        logic             w_full;
        logic [3:0]       aw_addr;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } ddi_state_t;

    localparam ddi_state_t STATE_RESET = '{sync1: '1, sync2: '1, ctrl: CTRL_RESET,
                                           conn: CONN_NONE, default: '0};

endpackage

// ==== verification/ddi_ctl_model.sv ====
// Purpose: Controller model driving the drive's radial and bused cable pins.
// Assumes: Lines are low-true and terminated to +5 V, so released lines read high.
// Notes:   The bench calls the tasks; every change follows a rising aclk edge.
`timescale 1ns/10ps
module ddi_ctl_model
    import ddi_pkg::*;
(
    // Clock and cable.
    input  wire logic aclk,
    output ddi_pins_t pins
);
    // Cables, terminator and power present; all other lines released high.
    initial pins = '{terminator_present_n: 1'h0, cables_present_n: 1'h0, default: '1};

    // Radial lines, given as high-true wishes and inverted onto the cable.
    task automatic lines(input logic seq, input logic sel, input logic ra, input logic rb);
        @(posedge aclk);
        pins.power_sequence_request_n <= ~seq;
        pins.unit_select_line_n       <= ~sel;
        pins.access_a_request_n       <= ~ra;
        pins.access_b_request_n       <= ~rb;
    endtask

    // One tag cycle; the bus is held over 200 ns either side, then the pull-ups win.
    task automatic tag(input int k, input logic [9:0] v);
        @(posedge aclk);
        pins.command_bus_lines_n <= ~v;
        repeat (5) @(posedge aclk);
        case (k)
            0:       pins.cylinder_load_strobe_n <= 1'h0;
            1:       pins.head_load_strobe_n     <= 1'h0;
            default: pins.command_strobe_n       <= 1'h0;
        endcase
        repeat (6) @(posedge aclk);
        pins.cylinder_load_strobe_n <= 1'h1;
        pins.head_load_strobe_n     <= 1'h1;
        pins.command_strobe_n       <= 1'h1;
        repeat (5) @(posedge aclk);
        pins.command_bus_lines_n <= '1;
    endtask
endmodule

// ==== verification/tb_top.sv ====
// Purpose: Self-checking bench for the drive input interface block.
// Assumes: Short fail-safe count; the controller model owns the cable pins.
// Notes:   Bus answers and seeks are noted in queues and matched by a monitor.
`timescale 1ns/10ps
module tb_top;
    import ddi_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, drive_ready = 1'h0;
    ddi_exer_t exer = '0;
    ddi_pins_t pins;
    logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'hF;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic unit_power_sequence_enable, select_acknowledge, attention, bus_receivers_enabled;
    logic rw_switch_lockout, input_interface_disable, output_interface_disable, rw_select_a;
    logic access_a_connected, access_b_connected, rw_select_b, seek_start, illegal_cylinder;
    logic end_of_cylinder, command_valid, awready, wready, bvalid, arready, rvalid;
    logic [9:0] cylinder_address, command_word, cyls [3], cmds [2];
    logic [4:0] head_address, heads [2];
    logic [1:0] offset_command, bresp, rresp;
    int err_total = 0, cmp_count = 0, cyc = 0;
    logic [33:0] bus_q [$];
    logic [9:0] seek_q [$];

    ddi_drive_if #(.FAILSAFE_COUNT(20)) u_dut (.aclk, .aresetn, .pins, .exer, .drive_ready,
        .unit_power_sequence_enable, .select_acknowledge, .attention, .bus_receivers_enabled,
        .rw_switch_lockout, .input_interface_disable, .output_interface_disable,
        .access_a_connected, .access_b_connected, .rw_select_a, .rw_select_b, .seek_start,
        .cylinder_address, .head_address, .offset_command, .illegal_cylinder, .end_of_cylinder,
        .command_valid, .command_word, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready);
    ddi_ctl_model u_ctl (.aclk, .pins);

    always #25 aclk = ~aclk;

    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Address and data go out together; each drops alone once taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        bus_q.push_back({r, 32'h0});
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        fork
            begin
                do @(posedge aclk); while (!awready);
                awvalid <= 1'h0;
            end
            begin
                do @(posedge aclk); while (!wready);
                wvalid <= 1'h0;
            end
        join
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        bus_q.push_back(e);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'h0;
    endtask

    // Monitor; an unexpected seek meets an impossible note and fails.
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            complete_run();
        end
        if (bvalid && bready)
            chk("bresp", bus_q.pop_front(), {bresp, 32'h0});
        if (rvalid && rready)
            chk("rdata", bus_q.pop_front(), {rresp, rdata});
        if (seek_start)
            chk("seek", seek_q.size() ? seek_q.pop_front() : '1, cylinder_address);
    end

    initial
    begin
        void'($urandom(66));
        cyls  = '{10'($urandom_range(814)), MAX_CYLINDER, MAX_CYLINDER + 10'h1};
        cmds  = '{10'h010, 10'h020};
        heads = '{5'h00, 5'h01};
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        rd(REG_CTRL, {RESP_OKAY, 32'h7});
        rd(4'hC, {RESP_SLVERR, 32'h0});
        wr(4'hC, $urandom, RESP_SLVERR);
        $display("Test registers done");
        drive_ready <= 1'h1;
        u_ctl.lines(1'h1, 1'h1, 1'h1, 1'h0);
        repeat (6) @(posedge aclk);
        chk("upse", 1'h1, unit_power_sequence_enable);
        chk("sel", 3'h7, {select_acknowledge, bus_receivers_enabled, rw_switch_lockout});
        chk("conn", 4'hA, {access_a_connected, access_b_connected, rw_select_a, rw_select_b});
        chk("attn", 1'h1, attention);
        u_ctl.lines(1'h0, 1'h1, 1'h1, 1'h0);
        repeat (6) @(posedge aclk);
        chk("upse", 1'h0, unit_power_sequence_enable);
        $display("Test select done");
        // Random legal cylinder, the last legal one, then the first illegal one.
        foreach (cyls[i])
        begin
            if (cyls[i] <= MAX_CYLINDER)
                seek_q.push_back(cyls[i]);
            u_ctl.tag(0, cyls[i]);
            repeat (4) @(posedge aclk);
            if (cyls[i] <= MAX_CYLINDER)
                chk("cyl", cyls[i], cylinder_address);
            chk("ill", cyls[i] > MAX_CYLINDER, illegal_cylinder);
        end
        u_ctl.tag(1, 10'h313);
        repeat (4) @(posedge aclk);
        chk("head", {2'h3, 5'h13, 1'h1}, {offset_command, head_address, end_of_cylinder});
        foreach (cmds[i])
        begin
            u_ctl.tag(2, cmds[i]);
            repeat (4) @(posedge aclk);
            chk("hcmd", {heads[i], 1'h0}, {head_address, end_of_cylinder});
        end
        u_ctl.tag(2, 10'h040);
        repeat (4) @(posedge aclk);
        chk("rezero", 11'h0, {cylinder_address, illegal_cylinder});
        $display("Test positioning done");
        u_ctl.lines(1'h0, 1'h1, 1'h1, 1'h1);
        repeat (30) @(posedge aclk);
        chk("connb", 4'h5, {access_a_connected, access_b_connected, rw_select_a, rw_select_b});
        u_ctl.lines(1'h0, 1'h0, 1'h0, 1'h1);
        u_ctl.tag(0, 10'h005);
        repeat (4) @(posedge aclk);
        chk("desel", 11'h0, {select_acknowledge, cylinder_address});
        $display("Test access done");
        // Offline with select asserted: the exerciser takes over the strobes.
        u_ctl.lines(1'h0, 1'h1, 1'h0, 1'h1);
        wr(REG_CTRL, ($urandom & 32'hFFFFFFF8) | 32'h6, RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk("off", 4'hE, {input_interface_disable, output_interface_disable,
            unit_power_sequence_enable, select_acknowledge});
        seek_q.push_back(10'h00B);
        exer <= '{bus: 10'h00B, cyl_strobe: 1'h1, default: '0};
        repeat (6) @(posedge aclk);
        exer.cyl_strobe <= 1'h0;
        repeat (6) @(posedge aclk);
        chk("exer", 10'h00B, cylinder_address);
        $display("Test offline done");
        complete_run();
    end
endmodule
